/* eic_top.sv */
// External interrupt conditioning with register port and controller decode
//
// Functional notes
// - After reset every input triggers on a low level.
// - Mode codes: 11 rising, 10 falling, 01 high level, 00 low level.
// - Input n mode field sits at bits 2n+1:2n of mode register.
// - Writing one to clear bit n clears request n.
// - Writing zero to a clear bit leaves that request unchanged.
// - Clear register is write-only; writes act only as clear strobes.
// - Conditioning registers take full-word accesses only.
// - Vectored controller registers accept word, halfword and byte accesses.
// - Vectored controller answers identically at primary and mirror base.
// - Level mode resamples pin after clear and re-raises if still active.
// - Every conditioned input reaches the controller as active-high level.
`timescale 1ns/1ps

`include "eic_cfg.svh"

module eic_top
    import eic_pkg::*;
#(
    parameter int NUM_INPUTS = `EIC_NUM_INPUTS
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire logic [31:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic [1:0]            reg_size,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // External pins
    input  wire logic [NUM_INPUTS-1:0] external_irq_pin,
    // Requests to the vectored controller
    output logic      [NUM_INPUTS-1:0] vectored_controller_request,
    // Vectored controller register window
    output logic                       vc_wr,
    output logic                       vc_rd,
    output logic      [11:0]           vc_addr,
    output logic      [1:0]            vc_size,
    output logic      [31:0]           vc_wdata,
    input  wire logic [31:0]           vc_rdata,
    // Interrupt to software
    output logic                       irq
);

    localparam int MW = 2 * NUM_INPUTS;

    // Conditioning page, full words only:
    //   080 trigger mode, two bits per input, bits 31:16 read zero
    //   084 request clear, write-only strobes, reads zero
    //   088 status, sticky request rises, cleared by reading it
    //   08c mask for the interrupt output
    //   090 current requests, read-only
    //   094 filtered pin levels, read-only
    // Anything else on the page reads zero and ignores writes.

    typedef struct packed {
        // Trigger modes
        logic [MW-1:0]         mode;
        // Three-stage pin filter and filtered level
        logic [NUM_INPUTS-1:0] sync1;
        logic [NUM_INPUTS-1:0] sync2;
        logic [NUM_INPUTS-1:0] sync3;
        logic [NUM_INPUTS-1:0] level;
        // Requests, sticky status and its mask
        logic [NUM_INPUTS-1:0] req;
        logic [NUM_INPUTS-1:0] status;
        logic [NUM_INPUTS-1:0] mask;
        // Read return
        logic [31:0]           rdata;
    } eic_state_t;

    eic_state_t st;
    eic_state_t next_st;

    // Trigger code of one input
    function automatic eic_trig_t eic_mode_of(
        input logic [MW-1:0] modes,
        input int            n
    );
        eic_mode_of = eic_trig_t'(modes[2*n +: 2]);
    endfunction : eic_mode_of

    // Page compare on the upper address bits
    function automatic logic eic_page_hit(
        input logic [31:0] addr,
        input logic [31:0] base
    );
        eic_page_hit = addr[31:`EIC_OFS_BITS] == base[31:`EIC_OFS_BITS];
    endfunction : eic_page_hit

    // Select one conditioning register for a full-word access only
    function automatic logic eic_reg_sel(
        input logic        strobe,
        input logic        page,
        input logic        word,
        input logic [11:0] offset,
        input logic [11:0] target
    );
        eic_reg_sel = strobe & page & word & (offset == target);
    endfunction : eic_reg_sel

    // Level request: follows the filtered pin, dropped for the clear cycle
    function automatic logic eic_level_req(
        input logic level,
        input logic active_high,
        input logic clear
    );
        logic active;
        active        = active_high ? level : ~level;
        eic_level_req = active & ~clear;
    endfunction : eic_level_req

    // Edge request: sticky until cleared; a new edge beats the clear
    function automatic logic eic_edge_req(
        input logic edge_seen,
        input logic held,
        input logic clear
    );
        eic_edge_req = edge_seen | (held & ~clear);
    endfunction : eic_edge_req

    // Filtered level moves only when the last two stages agree
    function automatic logic [NUM_INPUTS-1:0] eic_filter(
        input logic [NUM_INPUTS-1:0] stage2,
        input logic [NUM_INPUTS-1:0] stage3,
        input logic [NUM_INPUTS-1:0] held
    );
        eic_filter = (stage2 & stage3) | (held & (stage2 ^ stage3));
    endfunction : eic_filter

    // Register image for a full-word read of the conditioning page
    function automatic logic [31:0] eic_read_word(
        input eic_state_t  s,
        input logic [11:0] offset
    );
        case (offset)
            `EIC_OFS_MODE: begin
                eic_read_word = 32'(s.mode);
            end
            `EIC_OFS_STATUS: begin
                eic_read_word = 32'(s.status);
            end
            `EIC_OFS_MASK: begin
                eic_read_word = 32'(s.mask);
            end
            `EIC_OFS_REQ: begin
                eic_read_word = 32'(s.req);
            end
            `EIC_OFS_PIN: begin
                eic_read_word = 32'(s.level);
            end
            default: begin
                // Clear register reads as zero
                eic_read_word = '0;
            end
        endcase
    endfunction : eic_read_word

    // Address decode
    logic                  cond_hit;
    logic                  vc_pri_hit;
    logic                  vc_mir_hit;
    logic                  vc_hit;
    logic                  word_acc;
    logic [11:0]           ofs;
    logic                  wr_mode;
    logic                  wr_clear;
    logic                  wr_mask;
    logic                  rd_status;
    // Per-input strobes, edges and events
    logic [NUM_INPUTS-1:0] clr;
    logic [NUM_INPUTS-1:0] rise;
    logic [NUM_INPUTS-1:0] fall;
    logic [NUM_INPUTS-1:0] event_set;
    logic [NUM_INPUTS-1:0] pending;

    assign ofs      = reg_addr[11:0];
    assign cond_hit = eic_page_hit(reg_addr, `EIC_COND_BASE);
    // Both bases land on the same window offset
    assign vc_pri_hit = eic_page_hit(reg_addr, `EIC_VC_BASE);
    assign vc_mir_hit = eic_page_hit(reg_addr, `EIC_VC_MIRROR);
    assign vc_hit     = vc_pri_hit | vc_mir_hit;
    // Narrow accesses to the conditioning page are dropped, not merged
    assign word_acc = reg_size == EIC_WORD;

    // Mode bits 31:16 are not stored, so they always read back zero
    assign wr_mode   = eic_reg_sel(reg_wr, cond_hit, word_acc, ofs,
                                   `EIC_OFS_MODE);
    assign wr_clear  = eic_reg_sel(reg_wr, cond_hit, word_acc, ofs,
                                   `EIC_OFS_CLEAR);
    assign wr_mask   = eic_reg_sel(reg_wr, cond_hit, word_acc, ofs,
                                   `EIC_OFS_MASK);
    assign rd_status = eic_reg_sel(reg_rd, cond_hit, word_acc, ofs,
                                   `EIC_OFS_STATUS);

    // Ones clear, zeros do nothing; nothing of the write is stored
    assign clr = wr_clear ? reg_wdata[NUM_INPUTS-1:0]
                          : '0;

    // Window pass-through, any access size
    assign vc_wr    = reg_wr & vc_hit;
    assign vc_rd    = reg_rd & vc_hit;
    assign vc_addr  = reg_addr[11:0];
    assign vc_size  = reg_size;
    assign vc_wdata = reg_wdata;

    always_comb begin
        next_st = st;

        // Third stage only updates the filtered level once stages agree
        next_st.sync1 = external_irq_pin;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.level = eic_filter(st.sync2, st.sync3, st.level);
        // Edges come from the filtered level, so a pin glitch that the
        // last two stages never agree on cannot set an edge request
        rise = next_st.level & ~st.level;
        fall = ~next_st.level & st.level;

        // Limitation: a level request drops only for the clearing cycle.
        // If the source still drives its active level the request comes
        // straight back with a second status event; software must quiet
        // the source first and give the pin filter time to see it.
        for (int i = 0; i < NUM_INPUTS; i++) begin
            case (eic_mode_of(st.mode, i))
                EIC_RISE: begin
                    // Edge seen in the clearing cycle is kept
                    next_st.req[i] = eic_edge_req(rise[i], st.req[i],
                                                  clr[i]);
                end
                EIC_FALL: begin
                    next_st.req[i] = eic_edge_req(fall[i], st.req[i],
                                                  clr[i]);
                end
                EIC_HIGH: begin
                    // A clear drops the request one cycle, then resamples
                    next_st.req[i] = eic_level_req(
                        next_st.level[i], 1'b1, clr[i]);
                end
                EIC_LOW: begin
                    // Reset value of every mode field
                    next_st.req[i] = eic_level_req(
                        next_st.level[i], 1'b0, clr[i]);
                end
                default: begin
                    next_st.req[i] = st.req[i];
                end
            endcase
        end

        // Status catches every new request; set beats read-clear
        event_set = next_st.req & ~st.req;
        next_st.status = (rd_status ? '0 : st.status) | event_set;

        if (wr_mode) begin
            next_st.mode = reg_wdata[MW-1:0];
        end
        if (wr_mask) begin
            next_st.mask = reg_wdata[NUM_INPUTS-1:0];
        end

        // Read data stands one cycle after the strobe, zero otherwise
        next_st.rdata = '0;
        if (reg_rd) begin
            if (vc_hit) begin
                next_st.rdata = vc_rdata;
            end else if (cond_hit && word_acc) begin
                next_st.rdata = eic_read_word(st, ofs);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st.mode   <= MW'(`EIC_MODE_RESET);
            st.mask   <= NUM_INPUTS'(`EIC_MASK_RESET);
            // Idle pins assumed high so reset raises no low-level request
            st.sync1  <= '1;
            st.sync2  <= '1;
            st.sync3  <= '1;
            st.level  <= '1;
            st.req    <= '0;
            st.status <= '0;
            st.rdata  <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata                   = st.rdata;
    assign vectored_controller_request = st.req;
    // Level interrupt: any unmasked sticky status bit
    assign pending                     = st.status & st.mask;
    assign irq                         = |pending;

endmodule : eic_top

/* eic_cfg.svh */
// Addresses, field codes, reset values for external interrupt conditioning
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH

`define EIC_COND_BASE   32'hfffe2000
`define EIC_VC_BASE     32'hfffff000
`define EIC_VC_MIRROR   32'hffff0000
`define EIC_PAGE_BITS   20
`define EIC_OFS_BITS    12

`define EIC_OFS_MODE    12'h080
`define EIC_OFS_CLEAR   12'h084
`define EIC_OFS_STATUS  12'h088
`define EIC_OFS_MASK    12'h08c
`define EIC_OFS_REQ     12'h090
`define EIC_OFS_PIN     12'h094

`define EIC_MODE_RESET  32'h00000000
`define EIC_MASK_RESET  32'h00000000
`define EIC_NUM_INPUTS  8

`define EIC_TRIG_LOW    2'h0
`define EIC_TRIG_HIGH   2'h1
`define EIC_TRIG_FALL   2'h2
`define EIC_TRIG_RISE   2'h3

`define EIC_SIZE_BYTE   2'h0
`define EIC_SIZE_HALF   2'h1
`define EIC_SIZE_WORD   2'h2

`endif

/* eic_pkg.sv */
// Types shared by the external interrupt conditioning block
`include "eic_cfg.svh"

package eic_pkg;

    typedef enum logic [1:0] {
        EIC_LOW  = `EIC_TRIG_LOW,
        EIC_HIGH = `EIC_TRIG_HIGH,
        EIC_FALL = `EIC_TRIG_FALL,
        EIC_RISE = `EIC_TRIG_RISE
    } eic_trig_t;

    typedef enum logic [1:0] {
        EIC_BYTE = `EIC_SIZE_BYTE,
        EIC_HALF = `EIC_SIZE_HALF,
        EIC_WORD = `EIC_SIZE_WORD
    } eic_size_t;

endpackage : eic_pkg

/* eic_vc_model.sv */
// Vectored controller stand-in with combinational read data
`timescale 1ns/1ps
module eic_vc_model (
    // Register window
    input wire logic        vc_rd,
    input wire logic [11:0] vc_addr,
    output logic     [31:0] vc_rdata
);
    // Unselected bus shows the inverse so stale data never matches
    assign vc_rdata = {20'ha5a5a, vc_addr} ^ {32{!vc_rd}};
endmodule : eic_vc_model

/* eic_top_checker.sv */
// Port assertions for external interrupt conditioning
`timescale 1ns/1ps
module eic_top_checker
    import eic_pkg::*;
#(
    parameter int NUM_INPUTS = 8
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  sys_rst,
    // Register port
    input wire logic [31:0]           reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic [1:0]            reg_size,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [31:0]           reg_rdata,
    // Pins, requests and controller window
    input wire logic [NUM_INPUTS-1:0] external_irq_pin,
    input wire logic [NUM_INPUTS-1:0] vectored_controller_request,
    input wire logic                  vc_wr,
    input wire logic                  vc_rd,
    input wire logic [11:0]           vc_addr,
    input wire logic [1:0]            vc_size,
    input wire logic [31:0]           vc_wdata,
    input wire logic [31:0]           vc_rdata
);
    logic [NUM_INPUTS-1:0] pin_prev;
    logic [2:0]            quiet;
    logic                  cond;
    assign cond = reg_addr[31:12] == 20'hfffe2;
    // Clear checks only once the synchroniser cannot carry a late edge
    always_ff @(posedge sys_clk) begin
        pin_prev <= external_irq_pin;
        if (sys_rst || pin_prev != external_irq_pin || (reg_wr && cond))
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_clr;
        reg_wr && reg_size == 2'h2 && cond && reg_addr[11:0] == 12'h084
            && quiet > 3'h4;
    endsequence
    sequence s_rdc;
        reg_rd && cond;
    endsequence
    property p_clr_one;
        s_clr ##0 reg_wdata[0] |=> !vectored_controller_request[0];
    endproperty
    property p_clr_keep;
        s_clr ##0 (!reg_wdata[0] && vectored_controller_request[0])
            |=> vectored_controller_request[0];
    endproperty
    property p_clr_read;
        s_rdc ##0 reg_addr[11:0] == 12'h084 |=> reg_rdata == 32'h0;
    endproperty
    property p_half_read;
        s_rdc ##0 reg_size != 2'h2 |=> reg_rdata == 32'h0;
    endproperty
    property p_vc_pri;
        reg_wr && reg_addr[31:12] == 20'hfffff
            |-> vc_wr && vc_addr == reg_addr[11:0];
    endproperty
    property p_vc_mir;
        reg_rd && reg_addr[31:12] == 20'hffff0
            |-> vc_rd && vc_addr == reg_addr[11:0];
    endproperty
    property p_vc_fwd;
        vc_rd |=> reg_rdata == $past(vc_rdata);
    endproperty
    property p_vc_pass;
        vc_wr |-> vc_size == reg_size && vc_wdata == reg_wdata;
    endproperty
    property p_vc_none;
        cond |-> !vc_wr && !vc_rd;
    endproperty
    a_clr_one: assert property (p_clr_one) else $error("clear ignored");
    a_clr_keep: assert property (p_clr_keep) else $error("lost req");
    a_clr_read: assert property (p_clr_read) else $error("clr read");
    a_half_read: assert property (p_half_read) else $error("half rd");
    a_vc_pri: assert property (p_vc_pri) else $error("vc base");
    a_vc_mir: assert property (p_vc_mir) else $error("vc mirror");
    a_vc_fwd: assert property (p_vc_fwd) else $error("vc data");
    a_vc_none: assert property (p_vc_none) else $error("vc decode");
    a_vc_pass: assert property (p_vc_pass) else $error("vc size");
endmodule : eic_top_checker

bind eic_top eic_top_checker #(.NUM_INPUTS(NUM_INPUTS)) u_eic_top_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_irq_pin(external_irq_pin),
    .vectored_controller_request(vectored_controller_request),
    .vc_size(vc_size), .vc_wdata(vc_wdata),
    .vc_wr(vc_wr), .vc_rd(vc_rd), .vc_addr(vc_addr), .vc_rdata(vc_rdata)
);

/* eic_tb_top.sv */
// Bench for external interrupt conditioning against a bench model
`timescale 1ns/1ps
`include "eic_cfg.svh"
module eic_tb_top import eic_pkg::*;;
    localparam logic [31:0] MODE = `EIC_COND_BASE + `EIC_OFS_MODE;
    localparam logic [31:0] CLR = `EIC_COND_BASE + `EIC_OFS_CLEAR;
    localparam logic [31:0] STAT = `EIC_COND_BASE + `EIC_OFS_STATUS;
    localparam logic [31:0] MSK = `EIC_COND_BASE + `EIC_OFS_MASK;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0;
    logic        reg_rd = 1'b0, vc_rd, irq;
    logic [1:0]  reg_size = 2'h2;
    logic [11:0] vc_addr;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, vc_rdata, d;
    logic [7:0]  external_irq_pin = 8'hff, req, lat = 8'h0;
    logic [7:0]  stat = 8'h0, mask = 8'h0;
    int          mode[8] = '{default: 0};
    int          seed = 22, miscompares = 0, tests_run = 0, cycles = 0;
    eic_top u_eic_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_irq_pin(external_irq_pin),
        .vectored_controller_request(req), .vc_wr(), .vc_rd(vc_rd),
        .vc_addr(vc_addr), .vc_size(), .vc_wdata(), .vc_rdata(vc_rdata),
        .irq(irq)
    );
    eic_vc_model u_eic_vc_model (
        .vc_rd(vc_rd), .vc_addr(vc_addr), .vc_rdata(vc_rdata)
    );
    always #5 sys_clk = ~sys_clk;
    // The whole run needs about 950 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic cmp_reg(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_reg
    task automatic cmp_out(input logic [7:0] g, e);
        cmp_reg({24'h0, g}, {24'h0, e});
    endtask : cmp_out
    task automatic wr(input logic [31:0] a, w, input logic [1:0] s);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_size <= s;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [1:0] s);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_size <= s;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    function automatic logic [7:0] exp_req(input logic [7:0] p);
        for (int n = 0; n < 8; n++)
            exp_req[n] = mode[n] == 0 ? !p[n] : mode[n] == 1 ? p[n] : lat[n];
    endfunction : exp_req
    task automatic chk(input int n);
        repeat (n) @(posedge sys_clk);
        #1 cmp_out(req, exp_req(external_irq_pin));
        cmp_out({7'h0, irq}, {7'h0, |(stat & mask)});
    endtask : chk
    task automatic set_pins(input logic [7:0] p);
        logic [7:0] r;
        r = exp_req(external_irq_pin);
        for (int n = 0; n < 8; n++)
            if ((mode[n] == 3 && p[n] && !external_irq_pin[n]) ||
                (mode[n] == 2 && !p[n] && external_irq_pin[n]))
                lat[n] = 1'b1;
        stat |= exp_req(p) & ~r;
        @(posedge sys_clk);
        external_irq_pin <= p;
        chk(6);
    endtask : set_pins
    task automatic clr(input logic [7:0] c);
        logic [7:0] r;
        r = exp_req(external_irq_pin);
        // A still-active level source comes straight back
        for (int n = 0; n < 8; n++)
            if (c[n] && mode[n] < 2 && r[n])
                stat[n] = 1'b1;
        lat &= ~c;
        wr(CLR, {24'h0, c}, 2'h2);
        chk(6);
    endtask : clr
    initial begin
        logic [31:0] m;
        logic [15:0] mw;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(MODE, 2'h2);
        cmp_reg(d, `EIC_MODE_RESET);
        rd(CLR, 2'h2);
        cmp_reg(d, 32'h0);
        set_pins(8'hfe);
        for (int i = 0; i < 24; i++) begin
            m = $random(seed);
            mask = 8'h0;
            wr(MSK, 32'h0, 2'h2);
            wr(MODE, {16'h0, m[15:0]}, 2'h2);
            mw = m[15:0];
            for (int n = 0; n < 8; n++)
                mode[n] = int'(m[2*n +: 2]);
            rd(MODE, 2'h2);
            cmp_reg(d, {16'h0, m[15:0]});
            clr(8'hff);
            rd(STAT, 2'h2);
            stat = 8'h0;
            mask = m[23:16];
            wr(MSK, {24'h0, mask}, 2'h2);
            set_pins(m[31:24]);
            rd(STAT, 2'h2);
            cmp_reg(d, {24'h0, stat});
            stat = 8'h0;
            chk(1);
            m = $random(seed);
            clr(m[7:0]);
        end
        rd(MODE, 2'h1);
        cmp_reg(d, 32'h0);
        rd(MODE, 2'h2);
        cmp_reg(d, {16'h0, mw});
        rd(MODE, 2'h0);
        cmp_reg(d, 32'h0);
        mask = 8'h0;
        wr(MSK, 32'h0, 2'h2);
        wr(MODE, 32'h0, 2'h2);
        for (int n = 0; n < 8; n++)
            mode[n] = 0;
        set_pins(8'hff);
        clr(8'hff);
        set_pins(8'hfe);
        // Source goes quiet before the clear, so nothing comes back
        set_pins(8'hff);
        clr(8'h01);
        rd(`EIC_COND_BASE + 32'h200, 2'h2);
        cmp_reg(d, 32'h0);
        for (int k = 0; k < 6; k++) begin
            rd((k < 3 ? `EIC_VC_BASE : `EIC_VC_MIRROR) + 32'h30, 2'(k % 3));
            cmp_reg(d, 32'ha5a5a030);
        end
        wr(`EIC_VC_BASE + 32'h34, 32'h1, 2'h0);
        rd(`EIC_VC_MIRROR + 32'h34, 2'h0);
        cmp_reg(d, 32'ha5a5a034);
        end_of_test();
    end
endmodule : eic_tb_top
